//--- shared/ais_pkg.sv
// Constants shared by the analog input scaling block.
package ais_pkg;
	// ==========================================================
	// Register bus geometry: address is {object index, subindex}.
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned COEF_W = 16;
	localparam int unsigned VALUE_W = 32;
	localparam int unsigned RAW_W = 16;

	// ==========================================================
	// Object indices and subindex positions.
	localparam logic [15:0] IDX_VALUE = 16'h3320;
	localparam logic [15:0] IDX_OFFSET = 16'h3321;
	localparam logic [15:0] IDX_NUMER = 16'h3322;
	localparam logic [15:0] IDX_DENOM = 16'h3323;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_FIRST = 8'h01;

	// ==========================================================
	// Values after reset.
	localparam logic [15:0] RST_OFFSET = 16'h0000;
	localparam logic [15:0] RST_NUMER = 16'h0001;
	localparam logic [15:0] RST_DENOM = 16'h0001;
	localparam logic [31:0] RST_VALUE = 32'h00000000;
	localparam logic [31:0] RST_RDATA = 32'h00000000;

	// ==========================================================
	// Layout of one input's slice in the retained settings image.
	localparam int unsigned IMG_W = 48;
	localparam int unsigned IMG_OFF_POS = 0;
	localparam int unsigned IMG_NUM_POS = 16;
	localparam int unsigned IMG_DEN_POS = 32;
endpackage

//--- src/ais_scaler.sv
// One channel of offset, multiply and divide scaling with a registered result.
`timescale 1ns/1ps
`default_nettype none
module ais_scaler (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sample_i,
	input wire logic [ais_pkg::RAW_W-1:0] raw_i,
	input wire logic signed [ais_pkg::COEF_W-1:0] offset_i,
	input wire logic signed [ais_pkg::COEF_W-1:0] numer_i,
	input wire logic signed [ais_pkg::COEF_W-1:0] denom_i,
	output logic [ais_pkg::VALUE_W-1:0] value_o
);
	// ==========================================================
	// Datapath.
	logic signed [16:0] sum;
	logic signed [32:0] prod;
	logic signed [32:0] divisor;
	logic signed [32:0] quot;
	logic [ais_pkg::VALUE_W-1:0] value_d;
	logic [ais_pkg::VALUE_W-1:0] value_q;
	logic den_zero;

	always_comb begin
		sum = {raw_i[15], raw_i} + {offset_i[15], offset_i};
		prod = sum * numer_i;
		den_zero = (denom_i == 16'h0000);
		// The divisor is forced to one when zero so the divider never sees an illegal operand.
		divisor = den_zero ? 33'sh000000001 : {{17{denom_i[15]}}, denom_i};
		quot = prod / divisor;
		value_d = value_q;
		if (sample_i && !den_zero) begin
			value_d = quot[31:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			value_q <= ais_pkg::RST_VALUE;
		end else begin
			value_q <= value_d;
		end
	end

	assign value_o = value_q;

	// ==========================================================
	// Checks.
	unity_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sample_i && offset_i == 16'sh0000 && numer_i == 16'sh0001 && denom_i == 16'sh0001
		|=> value_o == {{16{$past(raw_i[15])}}, $past(raw_i)})
		else $error("unity scaling did not pass raw counts");
	zero_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		denom_i == 16'sh0000 |=> $stable(value_o))
		else $error("readout changed with zero denominator");
	idle_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!sample_i |=> $stable(value_o))
		else $error("readout changed without a sample");
	double_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sample_i && offset_i == 16'sh0000 && numer_i == 16'sh0002 && denom_i == 16'sh0001
		&& raw_i == 16'h0010 |=> value_o == 32'h00000020)
		else $error("numerator not applied");
	halve_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sample_i && offset_i == 16'sh0004 && numer_i == 16'sh0001 && denom_i == 16'sh0002
		&& raw_i == 16'h0010 |=> value_o == 32'h0000000A)
		else $error("offset or denominator not applied");
	zero_den_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) sample_i && denom_i == 16'sh0000);
endmodule
`default_nettype wire

//--- src/ais_top.sv
// Analog input scaling: coefficient registers, retention image and per-input scalers.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ais_top #(
	parameter int unsigned NUM_INPUTS = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ais_pkg::ADDR_W-1:0] addr_i,
	input wire logic [ais_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [ais_pkg::DATA_W-1:0] rdata_o,
	input wire logic sample_i,
	input wire logic [ais_pkg::RAW_W*NUM_INPUTS-1:0] adc_raw_i,
	output logic [ais_pkg::VALUE_W*NUM_INPUTS-1:0] value_o,
	input wire logic nv_restore_i,
	input wire logic [ais_pkg::IMG_W*NUM_INPUTS-1:0] nv_image_i,
	output logic [ais_pkg::IMG_W*NUM_INPUTS-1:0] nv_image_o
);
	// ==========================================================
	// Address decoding.
	function automatic logic addr_hit(input logic [23:0] a, input logic [15:0] idx, input logic [7:0] sub);
		return a == {idx, sub};
	endfunction

	localparam logic [7:0] INPUT_COUNT = 8'(NUM_INPUTS);

	logic [ais_pkg::COEF_W*NUM_INPUTS-1:0] off_flat;
	logic [ais_pkg::COEF_W*NUM_INPUTS-1:0] num_flat;
	logic [ais_pkg::COEF_W*NUM_INPUTS-1:0] den_flat;

	// ==========================================================
	// Per-input coefficient registers and scaler.
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : gen_in
		localparam logic [7:0] SUB = 8'(i + 1);
		logic [15:0] off_d;
		logic [15:0] off_q;
		logic [15:0] num_d;
		logic [15:0] num_q;
		logic [15:0] den_d;
		logic [15:0] den_q;

		always_comb begin
			off_d = off_q;
			num_d = num_q;
			den_d = den_q;
			// A restore carries the saved settings and so wins over a software write.
			if (nv_restore_i) begin
				off_d = nv_image_i[ais_pkg::IMG_W*i+ais_pkg::IMG_OFF_POS +: 16];
				num_d = nv_image_i[ais_pkg::IMG_W*i+ais_pkg::IMG_NUM_POS +: 16];
				den_d = nv_image_i[ais_pkg::IMG_W*i+ais_pkg::IMG_DEN_POS +: 16];
			end else if (wr_i) begin
				if (addr_hit(addr_i, ais_pkg::IDX_OFFSET, SUB)) begin
					off_d = wdata_i[15:0];
				end
				if (addr_hit(addr_i, ais_pkg::IDX_NUMER, SUB)) begin
					num_d = wdata_i[15:0];
				end
				if (addr_hit(addr_i, ais_pkg::IDX_DENOM, SUB)) begin
					den_d = wdata_i[15:0];
				end
			end
		end

		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				off_q <= ais_pkg::RST_OFFSET;
				num_q <= ais_pkg::RST_NUMER;
				den_q <= ais_pkg::RST_DENOM;
			end else begin
				off_q <= off_d;
				num_q <= num_d;
				den_q <= den_d;
			end
		end

		assign off_flat[16*i +: 16] = off_q;
		assign num_flat[16*i +: 16] = num_q;
		assign den_flat[16*i +: 16] = den_q;
		assign nv_image_o[ais_pkg::IMG_W*i +: ais_pkg::IMG_W] = {den_q, num_q, off_q};

		ais_scaler u_scaler (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.sample_i(sample_i),
			.raw_i(adc_raw_i[16*i +: 16]),
			.offset_i(off_q),
			.numer_i(num_q),
			.denom_i(den_q),
			.value_o(value_o[32*i +: 32])
		);
	end

	// ==========================================================
	// Read path: data stand only in the cycle after the strobe.
	logic [ais_pkg::DATA_W-1:0] rdata_d;
	logic [ais_pkg::DATA_W-1:0] rdata_q;

	always_comb begin
		rdata_d = ais_pkg::RST_RDATA;
		if (rd_i) begin
			if (addr_hit(addr_i, ais_pkg::IDX_VALUE, ais_pkg::SUB_COUNT)
				|| addr_hit(addr_i, ais_pkg::IDX_OFFSET, ais_pkg::SUB_COUNT)
				|| addr_hit(addr_i, ais_pkg::IDX_NUMER, ais_pkg::SUB_COUNT)
				|| addr_hit(addr_i, ais_pkg::IDX_DENOM, ais_pkg::SUB_COUNT)) begin
				rdata_d = {24'h000000, INPUT_COUNT};
			end
			// Subindices beyond the input count never match, so they read as zero.
			for (int i = 0; i < NUM_INPUTS; i++) begin
				if (addr_hit(addr_i, ais_pkg::IDX_VALUE, 8'(i + 1))) begin
					rdata_d = value_o[32*i +: 32];
				end
				if (addr_hit(addr_i, ais_pkg::IDX_OFFSET, 8'(i + 1))) begin
					rdata_d = {16'h0000, off_flat[16*i +: 16]};
				end
				if (addr_hit(addr_i, ais_pkg::IDX_NUMER, 8'(i + 1))) begin
					rdata_d = {16'h0000, num_flat[16*i +: 16]};
				end
				if (addr_hit(addr_i, ais_pkg::IDX_DENOM, 8'(i + 1))) begin
					rdata_d = {16'h0000, den_flat[16*i +: 16]};
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= ais_pkg::RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	// ==========================================================
	// Checks.
	numer_reset_a: assert property (@(posedge clk_i)
		!rst_n_i |=> num_flat[15:0] == 16'h0001)
		else $error("numerator not one after reset");
	denom_reset_a: assert property (@(posedge clk_i)
		!rst_n_i |=> den_flat[15:0] == 16'h0001 && off_flat[15:0] == 16'h0000)
		else $error("denominator or offset wrong after reset");
	count_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_NUMER, ais_pkg::SUB_COUNT} |=> rdata_o == {24'h000000, INPUT_COUNT})
		else $error("entry count misread");
	absent_sub_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_DENOM, 8'(NUM_INPUTS + 1)} |=> rdata_o == 32'h00000000)
		else $error("absent subindex did not read zero");
	numer_rw_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && !nv_restore_i && addr_i == {ais_pkg::IDX_NUMER, ais_pkg::SUB_FIRST}
		##1 rd_i && addr_i == {ais_pkg::IDX_NUMER, ais_pkg::SUB_FIRST}
		|=> rdata_o == {16'h0000, $past(wdata_i[15:0], 2)})
		else $error("numerator write not read back");
	denom_rw_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && !nv_restore_i && addr_i == {ais_pkg::IDX_DENOM, ais_pkg::SUB_FIRST}
		|=> den_flat[15:0] == $past(wdata_i[15:0]))
		else $error("denominator write lost");
	restore_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		nv_restore_i |=> nv_image_o == $past(nv_image_i))
		else $error("restore did not load saved settings");
	rdata_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!rd_i |=> rdata_o == 32'h00000000)
		else $error("read data outside read answer cycle");
	// ==========================================================
	// Map checks: every array answers its count and refuses absent or read-only entries.
	value_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_VALUE, ais_pkg::SUB_FIRST} |=> rdata_o == $past(value_o[31:0]))
		else $error("readout register does not match scaled value");
	count_value_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_VALUE, ais_pkg::SUB_COUNT} |=> rdata_o == {24'h000000, INPUT_COUNT})
		else $error("readout entry count misread");
	count_offset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_OFFSET, ais_pkg::SUB_COUNT} |=> rdata_o == {24'h000000, INPUT_COUNT})
		else $error("offset entry count misread");
	count_denom_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_DENOM, ais_pkg::SUB_COUNT} |=> rdata_o == {24'h000000, INPUT_COUNT})
		else $error("denominator entry count misread");
	count_locked_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && !nv_restore_i && addr_i[7:0] == ais_pkg::SUB_COUNT
		|=> $stable(num_flat) && $stable(den_flat) && $stable(off_flat))
		else $error("write to entry count changed a coefficient");
	offset_rw_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && !nv_restore_i && addr_i == {ais_pkg::IDX_OFFSET, ais_pkg::SUB_FIRST}
		|=> off_flat[15:0] == $past(wdata_i[15:0]))
		else $error("offset write lost");
	numer_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_i && !nv_restore_i && addr_i == {ais_pkg::IDX_NUMER, ais_pkg::SUB_FIRST}
		|=> num_flat[15:0] == $past(wdata_i[15:0]))
		else $error("numerator write lost");
	offset_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_OFFSET, ais_pkg::SUB_FIRST} |=> rdata_o == {16'h0000, $past(off_flat[15:0])})
		else $error("offset read wrong");
	denom_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_DENOM, ais_pkg::SUB_FIRST} |=> rdata_o == {16'h0000, $past(den_flat[15:0])})
		else $error("denominator read wrong");
	restore_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		nv_restore_i && wr_i |=> num_flat[15:0] == $past(nv_image_i[31:16]))
		else $error("software write beat a restore");
	absent_numer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_NUMER, 8'(NUM_INPUTS + 1)} |=> rdata_o == 32'h00000000)
		else $error("absent numerator did not read zero");
	absent_offset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_OFFSET, 8'(NUM_INPUTS + 1)} |=> rdata_o == 32'h00000000)
		else $error("absent offset did not read zero");
	absent_value_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_i && addr_i == {ais_pkg::IDX_VALUE, 8'(NUM_INPUTS + 1)} |=> rdata_o == 32'h00000000)
		else $error("absent readout did not read zero");
	write_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_i ##1 rd_i);
	restore_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) nv_restore_i ##2 sample_i);
	sample_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) sample_i ##1 rd_i && addr_i[23:8] == ais_pkg::IDX_VALUE);
endmodule
`default_nettype wire

//--- tb/ais_top_tb.sv
// Self-checking testbench for the analog input scaling block.
`timescale 1ns/1ps
`default_nettype none
module ais_top_tb;
	// ==========================================================
	// Stimulus and observed signals.
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ais_pkg::ADDR_W-1:0] addr_i = 24'h000000;
	logic [ais_pkg::DATA_W-1:0] wdata_i = 32'h00000000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic sample_i = 1'b0;
	logic [ais_pkg::RAW_W-1:0] adc_raw_i = 16'h0000;
	logic nv_restore_i = 1'b0;
	logic [ais_pkg::IMG_W-1:0] nv_image_i = 48'h000000000000;
	logic [ais_pkg::DATA_W-1:0] rdata_o;
	logic [ais_pkg::VALUE_W-1:0] value_o;
	logic [ais_pkg::IMG_W-1:0] nv_image_o;
	int n_errors = 0;
	int total_checks = 0;

	ais_top #(.NUM_INPUTS(1)) u_ais_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i), .adc_raw_i(adc_raw_i),
		.value_o(value_o), .nv_restore_i(nv_restore_i), .nv_image_i(nv_image_i), .nv_image_o(nv_image_o));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// ==========================================================
	// Shared bus and comparison tasks.
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [23:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= {16'h0000, d};
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so it is looked at there.
	task automatic rd_reg(input logic [23:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(48'(rdata_o), 48'(exp));
	endtask

	task automatic take_sample(input logic [15:0] raw, input logic [31:0] exp);
		@(posedge clk_i);
		adc_raw_i <= raw;
		sample_i <= 1'b1;
		@(posedge clk_i);
		sample_i <= 1'b0;
		#1 chk(48'(value_o), 48'(exp));
	endtask

	// ==========================================================
	// Scenarios.
	task automatic test_reset_map;
		rd_reg(24'h332201, 32'h00000001);
		rd_reg(24'h332301, 32'h00000001);
		rd_reg(24'h332101, 32'h00000000);
		wr_reg(24'h332200, 16'h0007);
		rd_reg(24'h332200, 32'h00000001);
		rd_reg(24'h332300, 32'h00000001);
		rd_reg(24'h332000, 32'h00000001);
		rd_reg(24'h332100, 32'h00000001);
		rd_reg(24'h332102, 32'h00000000);
		rd_reg(24'h332202, 32'h00000000);
		wr_reg(24'h332302, 16'h0009);
		rd_reg(24'h332302, 32'h00000000);
		@(posedge clk_i);
		#1 chk(48'(rdata_o), 48'h0);
	endtask

	task automatic test_scaling;
		take_sample(16'h0123, 32'h00000123);
		take_sample(16'hFFF0, 32'hFFFFFFF0);
		wr_reg(24'h332101, 16'h0004);
		wr_reg(24'h332201, 16'h0003);
		wr_reg(24'h332301, 16'h0002);
		take_sample(16'h0010, 32'(((16 + 4) * 3) / 2));
		wr_reg(24'h332201, 16'hFFFD);
		wr_reg(24'h332301, 16'h0007);
		take_sample(16'h0010, 32'(((16 + 4) * -3) / 7));
		rd_reg(24'h332201, 32'h0000FFFD);
		// A zero divisor must leave the last good readout in place.
		wr_reg(24'h332301, 16'h0000);
		take_sample(16'h0100, 32'(((16 + 4) * -3) / 7));
		rd_reg(24'h332001, 32'hFFFFFFF8);
		rd_reg(24'h332101, 32'h00000004);
	endtask

	task automatic test_restore;
		@(posedge clk_i);
		nv_image_i <= {16'h0005, 16'hFFFE, 16'h0002};
		nv_restore_i <= 1'b1;
		addr_i <= 24'h332201;
		wdata_i <= 32'h00000007;
		wr_i <= 1'b1;
		@(posedge clk_i);
		nv_restore_i <= 1'b0;
		wr_i <= 1'b0;
		#1 chk(nv_image_o, {16'h0005, 16'hFFFE, 16'h0002});
		rd_reg(24'h332201, 32'h0000FFFE);
		take_sample(16'h0008, 32'(((8 + 2) * -2) / 5));
	endtask

	// ==========================================================
	// Run control.
	task automatic give_verdict;
		$display("Checks: %0d, errors: %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1 chk(nv_image_o, {16'h0001, 16'h0001, 16'h0000});
		test_reset_map();
		test_scaling();
		test_restore();
		give_verdict();
	end

	// The whole run needs well under a thousand cycles.
	initial begin
		#20000;
		n_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
